//--- dac_ctrl_pkg.sv
package dac_ctrl_pkg;

	// Register offsets on the APB bus (byte addresses).
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] DATA_OFS   = 8'h04;
	localparam logic [7:0] LATCH_OFS  = 8'h08;
	localparam logic [7:0] STATUS_OFS = 8'h0C;
	localparam logic [7:0] OUT_OFS    = 8'h10;

	// Control register field positions.
	localparam int CLEAR_VALUE_SELECT_BIT_POS = 15;
	localparam int OVERRANGE_BIT_POS = 14;
	localparam int EXT_SET_RESISTOR_BIT_POS   = 13;
	localparam int OUTPUT_ENABLE_BIT_POS  = 12;
	localparam int SLEW_CTRL_ENABLE_BIT_POS   = 5;
	localparam int RANGE_LSB  = 0;

	// Status register field positions.
	localparam int IFAULT_POS = 2;
	localparam int OTEMP_POS  = 0;
	localparam int CLRACT_POS = 3;

	// Reset values.
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [15:0] CODE_RST = 16'h0000;

	// Output codes used by the default and clear values.
	localparam logic [15:0] CODE_ZERO = 16'h0000;
	localparam logic [15:0] CODE_MID  = 16'h8000;

	// Output range selection codes.
	typedef enum logic [2:0] {
		RNG_U5   = 3'b000,
		RNG_U10  = 3'b001,
		RNG_B5   = 3'b010,
		RNG_B10  = 3'b011,
		RNG_I420 = 3'b101,
		RNG_I020 = 3'b110,
		RNG_I024 = 3'b111
	} range_t;

	// Control fields travel together as one struct.
	typedef struct packed {
		logic   clear_value_select_bit;
		logic   overrange_bit;
		logic   ext_set_resistor_bit;
		logic   output_enable_bit;
		logic   slew_ctrl_enable_bit;
		range_t range;
	} ctrl_t;

	// Analog control outputs grouped for the converter core.
	typedef struct packed {
		logic [15:0] code;
		logic        volt_bipolar;
		logic        overrange;
		logic        ext_rset;
		logic        out_enable;
		logic        hart_enable;
		logic        slew_enable;
		logic        iout_clamp_low;
	} analog_t;

endpackage : dac_ctrl_pkg

//--- dac_clear_fault_control.sv
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ns
// Notes on behaviour
// - Fault alert is open-drain, active low.
// - Low headroom on current stage raises fault.
// - Over-temperature detector raises fault.
// - Separate status flags identify fault source.
// - Overrange bit widens voltage range ten percent.
// - Clear input high forces zero/mid code.
// - Clear selection is pin OR bit.
// - Selection sets clear and default values.
// - Clear drives current to range bottom.
// - Cleared value held after clear releases.
// - Bare latch pulse restores preclear value.
// - Data writes ignored while clear high.
// - New voltage range loads default value.
// - Enabling output loads default value.
// - Control bit selects external set resistor.
// - HART passes only while output enabled.
module dac_clear_fault_control (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  clk_en,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  clear_pin,
	input  wire logic                  clear_select_pin,
	input  wire logic                  headroom_low,
	input  wire logic                  over_temp,
	input  wire logic                  fault_alert_in,
	output logic                       fault_alert_out,
	output logic                       fault_alert_oe,
	output dac_ctrl_pkg::analog_t      analog
);
	import dac_ctrl_pkg::*;

	// Asynchronous pins pass two flip-flops; stage one is read only by stage two.
	logic [3:0] sync1_q;                         // First synchroniser stage.
	logic [3:0] sync2_q;                         // Second synchroniser stage.
	logic       clr_s;                           // Synchronised clear pin.
	logic       csel_s;                          // Synchronised clear select pin.
	logic       hdr_s;                           // Synchronised headroom alarm.
	logic       otp_s;                           // Synchronised temperature alarm.

	// Control and data state.
	ctrl_t       ctrl_q;                         // Control register.
	logic [15:0] data_q;                         // Input data register awaiting latch.
	logic        data_new_q;                     // Data written since last latch.
	logic [15:0] code_q;                         // Code presented to the converter.
	logic [15:0] preclr_q;                       // Value held before the clear.
	logic        clr_d1_q;                       // Delayed clear for edge detection.
	logic        fault_q;                        // Registered combined fault.

	// Bus decode.
	logic        acc;                            // Access phase, always one cycle.
	logic        wr;                             // Write strobe at completion.
	logic        hit_ctrl;                       // Control register selected.
	logic        hit_data;                       // Data register selected.
	logic        hit_latch;                      // Latch strobe register selected.
	logic        hit_stat;                       // Status register selected.
	logic        hit_out;                        // Output code register selected.
	logic        mapped;                         // Any register selected.
	ctrl_t       ctrl_new;                       // Control value being written.
	logic        eff_sel;                        // Effective clear selection.
	logic        bipolar;                        // Current range is bipolar voltage.
	logic        cur_mode;                       // Current range is a current range.
	logic [15:0] dflt_code;                      // Default and clear code.
	logic        new_sel;                        // Selection once the control write lands.
	logic        new_bip;                        // Written range is bipolar voltage.
	logic [15:0] dflt_new;                       // Default code for the written control word.
	logic        rng_change;                     // Write selects a new range.
	logic        en_rise;                        // Write sets the enable bit.
	logic        clr_rise;                       // Clear pin just went high.

	assign clr_s  = sync2_q[0];
	assign csel_s = sync2_q[1];
	assign hdr_s  = sync2_q[2];
	assign otp_s  = sync2_q[3];

	// The slave answers in the first access cycle, so pready is simply high.
	assign acc       = psel & penable;
	assign wr        = acc & pwrite & clk_en;
	assign hit_ctrl  = (paddr == CTRL_OFS);
	assign hit_data  = (paddr == DATA_OFS);
	assign hit_latch = (paddr == LATCH_OFS);
	assign hit_stat  = (paddr == STATUS_OFS);
	assign hit_out   = (paddr == OUT_OFS);
	assign mapped    = hit_ctrl | hit_data | hit_latch | hit_stat | hit_out;
	assign pready    = 1'b1;
	assign pslverr   = acc & ~mapped;

	// Field unpacking of the written control word.
	assign ctrl_new.clear_value_select_bit = pwdata[CLEAR_VALUE_SELECT_BIT_POS];
	assign ctrl_new.overrange_bit          = pwdata[OVERRANGE_BIT_POS];
	assign ctrl_new.ext_set_resistor_bit   = pwdata[EXT_SET_RESISTOR_BIT_POS];
	assign ctrl_new.output_enable_bit      = pwdata[OUTPUT_ENABLE_BIT_POS];
	assign ctrl_new.slew_ctrl_enable_bit   = pwdata[SLEW_CTRL_ENABLE_BIT_POS];
	assign ctrl_new.range                  = range_t'(pwdata[RANGE_LSB +: 3]);

	// The selection is the OR of pin and bit.
	assign eff_sel  = csel_s | ctrl_q.clear_value_select_bit;
	assign cur_mode = ctrl_q.range[2];
	assign bipolar  = (ctrl_q.range == RNG_B5) | (ctrl_q.range == RNG_B10);
	// Select 0 gives 0 V (bottom code unipolar, midscale bipolar).
	// Select 1 gives midscale unipolar and the bottom code on bipolar ranges.
	assign dflt_code = (eff_sel ^ bipolar) ? CODE_MID : CODE_ZERO;
	// A range or enable write must use the word being written, not the old one.
	assign new_sel  = csel_s | ctrl_new.clear_value_select_bit;
	assign new_bip  = (ctrl_new.range == RNG_B5) | (ctrl_new.range == RNG_B10);
	assign dflt_new = (new_sel ^ new_bip) ? CODE_MID : CODE_ZERO;

	assign rng_change = wr & hit_ctrl & (ctrl_new.range != ctrl_q.range);
	assign en_rise    = wr & hit_ctrl & ctrl_new.output_enable_bit
	                    & ~ctrl_q.output_enable_bit;
	assign clr_rise   = clr_s & ~clr_d1_q;

	// Two-stage synchroniser for all asynchronous pins.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= 4'h0;
			sync2_q <= 4'h0;
		end else if (clk_en) begin
			sync1_q <= {over_temp, headroom_low, clear_select_pin, clear_pin};
			sync2_q <= sync1_q;
		end
	end

	// Control register; the control word lives at this bus offset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= ctrl_t'(CTRL_RST[$bits(ctrl_t)-1:0]);
		end else if (wr && hit_ctrl) begin
			ctrl_q <= ctrl_new;
		end
	end

	// Input data register refuses writes while clear is high.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_q     <= CODE_RST;
			data_new_q <= 1'b0;
		end else if (wr && hit_data && !clr_s) begin
			data_q     <= pwdata[15:0];
			data_new_q <= 1'b1;
		end else if (wr && hit_latch && !clr_s) begin
			data_new_q <= 1'b0;
		end
	end

	// Output code: clear, default loads, latch and restore.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			code_q   <= CODE_RST;
			preclr_q <= CODE_RST;
			clr_d1_q <= 1'b0;
		end else if (clk_en) begin
			clr_d1_q <= clr_s;
			if (clr_rise) begin
				// Keep the value so a bare latch can bring it back.
				preclr_q <= code_q;
				code_q   <= dflt_code;
			end else if (clr_s) begin
				// Held at the clear code; the output mux forces range bottom in current mode.
				code_q <= dflt_code;
			end else if (rng_change || en_rise) begin
				code_q <= dflt_new;
			end else if (wr && hit_latch) begin
				// A latch without new data restores the preclear value.
				code_q <= data_new_q ? data_q : preclr_q;
			end
			// Otherwise the cleared value simply stays.
		end
	end

	// Fault alert tracks both detectors and drops when both are gone.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_q <= 1'b0;
		end else if (clk_en) begin
			fault_q <= hdr_s | otp_s;
		end
	end

	// Open drain: only ever pull low.
	assign fault_alert_out = 1'b0;
	assign fault_alert_oe  = fault_q;

	// Analog controls; current mode forces code to range bottom on clear.
	assign analog.code           = (clr_s & cur_mode) ? CODE_ZERO : code_q;
	assign analog.volt_bipolar   = bipolar;
	assign analog.overrange      = ctrl_q.overrange_bit;
	assign analog.ext_rset       = ctrl_q.ext_set_resistor_bit;
	assign analog.out_enable     = ctrl_q.output_enable_bit;
	assign analog.hart_enable    = ctrl_q.output_enable_bit & cur_mode;
	assign analog.slew_enable    = ctrl_q.slew_ctrl_enable_bit;
	assign analog.iout_clamp_low = clr_s & cur_mode;

	// Read mux; status shows each fault source separately.
	always_comb begin
		prdata = 32'h0;
		if (acc && !pwrite) begin
			if (hit_ctrl) begin
				prdata[CLEAR_VALUE_SELECT_BIT_POS]     = ctrl_q.clear_value_select_bit;
				prdata[OVERRANGE_BIT_POS]     = ctrl_q.overrange_bit;
				prdata[EXT_SET_RESISTOR_BIT_POS]       = ctrl_q.ext_set_resistor_bit;
				prdata[OUTPUT_ENABLE_BIT_POS]      = ctrl_q.output_enable_bit;
				prdata[SLEW_CTRL_ENABLE_BIT_POS]       = ctrl_q.slew_ctrl_enable_bit;
				prdata[RANGE_LSB +: 3] = ctrl_q.range;
			end else if (hit_data) begin
				prdata[15:0] = data_q;
			end else if (hit_stat) begin
				prdata[IFAULT_POS] = hdr_s;
				prdata[OTEMP_POS]  = otp_s;
				prdata[CLRACT_POS] = clr_s;
			end else if (hit_out) begin
				prdata[15:0] = code_q;
			end
		end
	end

endmodule : dac_clear_fault_control

//--- host_pins.sv
`timescale 1ns/1ns
// Host side of the pins: stretches clear and pulls the shared alert line up.
module host_pins #(
	parameter int MIN_CLR = 4 // Clear cycles added after the request cycle, a plain default.
) (
	input  wire logic pclk,
	input  wire logic clear_req,
	output logic      clear_pin,
	input  wire logic fault_alert_out,
	input  wire logic fault_alert_oe,
	output logic      fault_line
);
	logic [3:0] hold_q = 4'h0; // Clear cycles still owed.
	initial clear_pin = 1'b0;
	// A short request is stretched so that every clear completes.
	always @(posedge pclk) begin
		clear_pin <= clear_req | (hold_q != 4'h0);
		hold_q    <= clear_req ? 4'(MIN_CLR) : hold_q - 4'(hold_q != 4'h0);
	end
	// The line idles high through the pull-up unless a device sinks it.
	assign fault_line = fault_alert_oe ? fault_alert_out : 1'b1;
endmodule : host_pins

//--- dac_ctrl_asserts.sv
`timescale 1ns/1ns
// Watches the alert, clear and bus behaviour at the block's ports.
module dac_ctrl_asserts (
	input wire logic                  pclk,
	input wire logic                  presetn,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [7:0]            paddr,
	input wire logic [31:0]           prdata,
	input wire logic                  clear_pin,
	input wire logic                  headroom_low,
	input wire logic                  over_temp,
	input wire logic                  fault_alert_out,
	input wire logic                  fault_alert_oe,
	input wire dac_ctrl_pkg::analog_t analog
);
	import dac_ctrl_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Five cycles covers the two-flop synchroniser plus the alert register.
	sequence hr_held; headroom_low[*5]; endsequence
	sequence status_rd; psel && penable && !pwrite && paddr == STATUS_OFS; endsequence
	alert_drain_a: assert property (!fault_alert_out) else $error("alert drove high");
	headroom_alert_a: assert property (hr_held |-> fault_alert_oe) else $error("no alert");
	temp_alert_a: assert property (over_temp[*5] |-> fault_alert_oe) else $error("no alert");
	alert_release_a: assert property ((!headroom_low && !over_temp)[*5] |-> !fault_alert_oe)
		else $error("alert stuck");
	fault_flag_a: assert property (hr_held ##0 status_rd |-> prdata[IFAULT_POS])
		else $error("fault flag missing");
	hart_gate_a: assert property (analog.hart_enable |-> analog.out_enable)
		else $error("hart while off");
	clear_code_a: assert property (clear_pin[*6] |-> analog.code inside {CODE_ZERO, CODE_MID})
		else $error("clear code wrong");
	clear_block_a: assert property (clear_pin[*7] |=> $stable(analog.code))
		else $error("code moved in clear");
endmodule : dac_ctrl_asserts
bind dac_clear_fault_control dac_ctrl_asserts dac_ctrl_asserts_i (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .clear_pin(clear_pin), .headroom_low(headroom_low),
	.over_temp(over_temp), .fault_alert_out(fault_alert_out),
	.fault_alert_oe(fault_alert_oe), .analog(analog));

//--- tb.sv
`timescale 1ns/1ns
module tb;
	import dac_ctrl_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, clear_req = 1'b0, clear_pin, clear_select_pin = 1'b0;
	logic headroom_low = 1'b0, over_temp = 1'b0, fault_line, fault_alert_out, fault_alert_oe;
	analog_t analog;
	int n_mismatch = 0, n_checks = 0;
	always #4 pclk = ~pclk;
	dac_clear_fault_control dac_clear_fault_control_i (.pclk(pclk), .presetn(presetn),
		.clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.clear_pin(clear_pin), .clear_select_pin(clear_select_pin),
		.headroom_low(headroom_low), .over_temp(over_temp), .fault_alert_in(fault_line),
		.fault_alert_out(fault_alert_out), .fault_alert_oe(fault_alert_oe), .analog(analog));
	host_pins host_pins_i (.pclk(pclk), .clear_req(clear_req), .clear_pin(clear_pin),
		.fault_alert_out(fault_alert_out), .fault_alert_oe(fault_alert_oe),
		.fault_line(fault_line));
	// One APB transfer; the request holds until pready is seen high.
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	// Control word writer; field order follows the control struct.
	task automatic wctl(input logic s, o, e, en, sl, input range_t r);
		xfer(1'b1, CTRL_OFS, {16'h0, s, o, e, en, 6'h00, sl, 2'h0, r});
	endtask : wctl
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic complete_run;
		$display("checks %0d, mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run
	// Watchdog sized well above the 120-odd cycles the tests need.
	initial begin
		#200000;
		n_mismatch++;
		complete_run();
	end
	initial begin
		cyc(10);
		presetn <= 1'b1;
		wctl(0, 0, 0, 1, 0, RNG_U10);
		xfer(0, OUT_OFS, 0);
		chk("enable default", 32'h0, rd);
		wctl(0, 0, 0, 0, 0, RNG_U10);
		wctl(1, 1, 1, 1, 1, RNG_U5);
		xfer(0, OUT_OFS, 0);
		chk("mid default", 32'h8000, rd);
		chk("overrange", 32'h1, analog.overrange);
		chk("ext resistor", 32'h1, analog.ext_rset);
		wctl(0, 0, 0, 0, 0, RNG_B5);
		xfer(0, OUT_OFS, 0);
		chk("bipolar default", 32'h8000, rd);
		wctl(0, 0, 0, 1, 0, RNG_U5);
		xfer(0, OUT_OFS, 0);
		chk("unipolar default", 32'h0, rd);
		xfer(1, DATA_OFS, 32'h1234);
		xfer(1, LATCH_OFS, 0);
		cyc(3);
		chk("latched code", 32'h1234, analog.code);
		clear_select_pin <= 1'b1;
		clear_req        <= 1'b1;
		cyc(6);
		chk("clear code", 32'h8000, analog.code);
		xfer(1, DATA_OFS, 32'h5555);
		xfer(1, LATCH_OFS, 0);
		clear_req        <= 1'b0;
		cyc(8);
		chk("held code", 32'h8000, analog.code);
		clear_select_pin <= 1'b0;
		xfer(1, LATCH_OFS, 0);
		cyc(3);
		chk("restored code", 32'h1234, analog.code);
		wctl(0, 0, 0, 0, 1, RNG_I420);
		cyc(3);
		chk("hart off", 32'h0, analog.hart_enable);
		wctl(0, 0, 0, 1, 1, RNG_I420);
		cyc(3);
		chk("hart on", 32'h1, analog.hart_enable);
		clear_req <= 1'b1;
		cyc(6);
		chk("current clamp", 32'h1, analog.iout_clamp_low);
		chk("current clear code", 32'h0, analog.code);
		clear_req <= 1'b0;
		for (int k = 0; k < 2; k++) begin
			headroom_low <= (k == 0);
			over_temp    <= (k == 1);
			cyc(6);
			chk("alert line", 32'h0, fault_line);
			xfer(0, STATUS_OFS, 0);
			chk("fault flags", (k == 0) ? 2'b10 : 2'b01, {rd[IFAULT_POS], rd[OTEMP_POS]});
			headroom_low <= 1'b0;
			over_temp    <= 1'b0;
			cyc(6);
			chk("alert released", 32'h1, fault_line);
		end
		xfer(0, 8'h14, 0);
		chk("unmapped error", 32'h1, err);
		complete_run();
	end
endmodule : tb
